// ### hw/playback_pkg.sv
// Purpose: Shared constants and types for the flash sample PWM playback block.
// Assumes: An SPI serial flash that answers the plain read command with a 24-bit address.
// Notes: The timer source clock must already run at the rate that the chosen sample rate needs.
// Functional notes
// - Sample rate is a build-time choice of 44100, 22050, 16000 or 8000 Hz.
// - Clip length is a 32-bit count of 8-bit samples.
// - Clip base is a 32-bit input whose low 24 bits give the flash location of the first sample.
// - SPI clock runs at the same rate as the sample timer tick.
// - Flash reads are polled, never delaying the sample-period update.
// - Each sample-period event loads the latest fetched sample into the duty compare.
// - Each sample fetch checks fetch-ahead limit and clip length bound; each sample-period event checks the clip end.
// - A trigger clears position and counters, then starts the selected clip if its length is nonzero.
// - Two timer channels: one sets the period, one gives the duty output.
// - Select, amp-off and tone pins each choose default (0) or alternate (1).
// - Debug toggles one pin per SPI transaction, another on service entry and exit.
// - Debug drives the timer clock onto a pin for observation.
// - One button steps through three clips, the other alternates the first two.
// - Playback start configures the timer; its source clock must already be right.
package playback_pkg;

    typedef enum logic [1:0] {
        RATE_OPTION_HIGHEST = 2'b00,
        RATE_OPTION_HALF = 2'b01,
        RATE_OPTION_WIDEBAND = 2'b10,
        RATE_OPTION_NARROWBAND = 2'b11
    } rate_option_t;

    localparam int RATE_HIGHEST_HZ = 44100;
    localparam int RATE_HALF_HZ = 22050;
    localparam int RATE_WIDEBAND_HZ = 16000;
    localparam int RATE_NARROWBAND_HZ = 8000;

    localparam int PWM_COUNTS = 256;
    localparam int CYCLES_PER_TICK = 2;
    localparam int CLIP_COUNT = 3;

    localparam logic [7:0] READ_CMD = 8'h03;
    localparam logic [5:0] CMD_BITS = 6'h20;
    localparam logic [5:0] SAMPLE_BITS = 6'h08;
    localparam logic [7:0] DUTY_RESET = 8'h00;
    localparam logic [7:0] TIMER_TOP = 8'hFF;
    localparam logic [1:0] CLIP_RESET = 2'h0;

    typedef enum logic [2:0] {
        LINK_IDLE = 3'b000,
        LINK_GAP = 3'b001,
        LINK_CMD = 3'b010,
        LINK_DATA = 3'b011,
        LINK_HOLD = 3'b100
    } link_state_t;

    function automatic int rate_hz(input rate_option_t sel);
        case (sel)
            RATE_OPTION_HIGHEST: rate_hz = RATE_HIGHEST_HZ;
            RATE_OPTION_HALF: rate_hz = RATE_HALF_HZ;
            RATE_OPTION_WIDEBAND: rate_hz = RATE_WIDEBAND_HZ;
            default: rate_hz = RATE_NARROWBAND_HZ;
        endcase
    endfunction

endpackage

// ### hw/flash_sample_pwm_playback.sv
// Purpose: Streams 8-bit samples from SPI flash into a 256-count PWM timer.
// Assumes: timer_source_clock runs free at 512 times the sample rate.
// Notes: Control sits on sys_clk; SPI and timer run on timer_source_clock.
module flash_sample_pwm_playback
    import playback_pkg::*;
#(
    parameter rate_option_t RATE_SEL = RATE_OPTION_HIGHEST,
    parameter bit DEBUG_ENABLE = 1'b0,
    parameter bit FLASH_SELECT_PIN_SWAP = 1'b0,
    parameter bit AMP_OFF_PIN_SWAP = 1'b0,
    parameter bit TONE_OUTPUT_PIN_SWAP = 1'b0
)
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic timer_source_clock,
    input wire logic btn_cycle,
    input wire logic btn_pair,
    input wire logic [31:0] clip_sample_count_0,
    input wire logic [31:0] clip_sample_count_1,
    input wire logic [31:0] clip_sample_count_2,
    input wire logic [31:0] clip_base_location_0,
    input wire logic [31:0] clip_base_location_1,
    input wire logic [31:0] clip_base_location_2,
    input wire logic flash_miso,
    output logic flash_sclk,
    output logic flash_mosi,
    output logic flash_select_n_main,
    output logic flash_select_n_alt,
    output logic amp_off_main,
    output logic amp_off_alt,
    output logic tone_out_main,
    output logic tone_out_alt,
    output logic debug_spi_toggle,
    output logic debug_service_toggle,
    output logic debug_timer_clock,
    output logic playing,
    output logic [1:0] clip_select
);

    // The source clock must be this fast for the chosen rate; nothing here can check it.
    localparam int SOURCE_HZ = rate_hz(RATE_SEL) * PWM_COUNTS * CYCLES_PER_TICK;
    typedef struct packed {
        logic [1:0] cyc_sync;
        logic [1:0] pair_sync;
        logic cyc_prev;
        logic pair_prev;
        logic [1:0] clip;
        logic req_tgl;
        logic [31:0] len;
        logic [31:0] base;
        logic [1:0] busy_sync;
    } sys_state_t;

    typedef struct packed {
        logic [1:0] en_sync;
        logic [1:0] req_sync;
        logic req_seen;
        link_state_t st;
        logic ph;
        logic [5:0] bit_cnt;
        logic [31:0] shreg;
        logic [7:0] buf_data;
        logic buf_valid;
        logic [31:0] fetched;
        logic [31:0] played;
        logic [31:0] len;
        logic [7:0] tcount;
        logic [7:0] duty;
        logic busy;
        logic sclk;
        logic mosi;
        logic cs_n;
        logic amp_off;
        logic pwm;
        logic [1:0] cs_pins;
        logic [1:0] amp_pins;
        logic [1:0] tone_pins;
        logic dbg_spi;
        logic dbg_svc;
        logic dbg_clk;
        logic svc_exit;
    } link_state_rec_t;

    sys_state_t s;
    sys_state_t next_s;
    link_state_rec_t l;
    link_state_rec_t next_l;
    logic [1:0] sys_rst_q;
    logic [1:0] link_rst_q;
    logic sys_rst_n;
    logic link_rst_n;
    logic press_cyc;
    logic press_pair;
    logic sample_event;
    logic trig;
    logic done_now;

    // Index 0 is the default pin, index 1 the alternate; the unused pin rests at idle.
    function automatic logic [1:0] route(input logic val, input logic swap, input logic idle);
        route = swap ? {val, idle} : {idle, val};
    endfunction

    function automatic logic [31:0] pick_word(input logic [1:0] idx, input logic [31:0] w0,
                                              input logic [31:0] w1, input logic [31:0] w2);
        case (idx)
            2'h0: pick_word = w0;
            2'h1: pick_word = w1;
            default: pick_word = w2;
        endcase
    endfunction

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            sys_rst_q <= 2'h0;
        else
            sys_rst_q <= {sys_rst_q[0], 1'b1};
    end
    always_ff @(posedge timer_source_clock or negedge reset_n)
    begin
        if (!reset_n)
            link_rst_q <= 2'h0;
        else
            link_rst_q <= {link_rst_q[0], 1'b1};
    end

    assign sys_rst_n = sys_rst_q[1];
    assign link_rst_n = link_rst_q[1];
    assign press_cyc = s.cyc_sync[1] & ~s.cyc_prev;
    assign press_pair = s.pair_sync[1] & ~s.pair_prev;
    always_comb
    begin
        next_s = s;
        next_s.cyc_sync = {s.cyc_sync[0], btn_cycle};
        next_s.pair_sync = {s.pair_sync[0], btn_pair};
        next_s.cyc_prev = s.cyc_sync[1];
        next_s.pair_prev = s.pair_sync[1];
        next_s.busy_sync = {s.busy_sync[0], l.busy};
        if (press_cyc)
            next_s.clip = (s.clip == 2'(CLIP_COUNT - 1)) ? 2'h0 : s.clip + 2'h1;
        else if (press_pair)
            next_s.clip = (s.clip == 2'h0) ? 2'h1 : 2'h0;
        if (press_cyc || press_pair)
        begin
            // Length and base stay still until the next press, so the link reads them safely.
            next_s.req_tgl = ~s.req_tgl;
            next_s.len = pick_word(next_s.clip, clip_sample_count_0, clip_sample_count_1,
                                   clip_sample_count_2);
            next_s.base = pick_word(next_s.clip, clip_base_location_0, clip_base_location_1,
                                    clip_base_location_2);
        end
    end

    always_ff @(posedge sys_clk or negedge sys_rst_n)
    begin
        if (!sys_rst_n)
            s <= '0;
        else if (clk_en)
            s <= next_s;
    end

    assign trig = l.en_sync[1] && (l.req_sync[1] != l.req_seen);
    assign sample_event = l.en_sync[1] && l.busy && l.ph && (l.tcount == TIMER_TOP);
    assign done_now = (l.buf_valid ? 32'(l.played + 32'h1) : l.played) >= l.len;
    always_comb
    begin
        next_l = l;
        next_l.en_sync = {l.en_sync[0], clk_en};
        if (l.en_sync[1])
        begin
            next_l.ph = ~l.ph;
            next_l.req_sync = {l.req_sync[0], s.req_tgl};
            next_l.req_seen = l.req_sync[1];
            next_l.dbg_clk = DEBUG_ENABLE & ~l.dbg_clk;
            next_l.svc_exit = 1'b0;
            if (l.svc_exit)
                next_l.dbg_svc = DEBUG_ENABLE & ~l.dbg_svc;
            if (l.busy && l.ph)
                next_l.tcount = l.tcount + 8'h01;
            next_l.pwm = l.busy && (l.tcount < l.duty);
            // The SPI engine advances on its own every cycle, so it never holds up the timer.
            case (l.st)
                LINK_GAP:
                begin
                    next_l.cs_n = 1'b0;
                    if (l.ph)
                    begin
                        next_l.st = LINK_CMD;
                        next_l.dbg_spi = DEBUG_ENABLE & ~l.dbg_spi;
                    end
                end
                LINK_CMD, LINK_DATA:
                begin
                    if (!l.ph)
                    begin
                        next_l.sclk = 1'b0;
                        next_l.mosi = l.shreg[31];
                    end
                    else
                    begin
                        next_l.sclk = 1'b1;
                        next_l.shreg = {l.shreg[30:0], flash_miso};
                        next_l.bit_cnt = l.bit_cnt - 6'h01;
                        if (l.bit_cnt == 6'h01)
                        begin
                            next_l.st = LINK_HOLD;
                            if (l.st == LINK_DATA)
                            begin
                                next_l.buf_data = {l.shreg[6:0], flash_miso};
                                next_l.buf_valid = 1'b1;
                                next_l.fetched = l.fetched + 32'h1;
                            end
                        end
                    end
                end
                LINK_HOLD:
                begin
                    next_l.sclk = 1'b0;
                    // Only one sample is fetched ahead of the one playing.
                    if (l.ph && !l.buf_valid && (l.fetched < l.len))
                    begin
                        next_l.st = LINK_DATA;
                        next_l.bit_cnt = SAMPLE_BITS;
                        next_l.dbg_spi = DEBUG_ENABLE & ~l.dbg_spi;
                    end
                end
                default:
                begin
                    next_l.sclk = 1'b0;
                end
            endcase
            if (sample_event)
            begin
                next_l.dbg_svc = DEBUG_ENABLE & ~l.dbg_svc;
                next_l.svc_exit = 1'b1;
                // An underrun repeats the previous duty rather than glitching the output.
                if (l.buf_valid)
                begin
                    next_l.duty = l.buf_data;
                    next_l.buf_valid = 1'b0;
                    next_l.played = l.played + 32'h1;
                end
                if (done_now)
                begin
                    next_l.busy = 1'b0;
                    next_l.st = LINK_IDLE;
                    next_l.cs_n = 1'b1;
                    next_l.sclk = 1'b0;
                end
            end
            if (trig)
            begin
                next_l.busy = (s.len != 32'h0);
                next_l.st = (s.len != 32'h0) ? LINK_GAP : LINK_IDLE;
                next_l.len = s.len;
                next_l.shreg = {READ_CMD, s.base[23:0]};
                next_l.bit_cnt = CMD_BITS;
                next_l.fetched = 32'h0;
                next_l.played = 32'h0;
                next_l.buf_valid = 1'b0;
                next_l.tcount = 8'h00;
                next_l.duty = DUTY_RESET;
                next_l.cs_n = 1'b1;
                next_l.sclk = 1'b0;
            end
        end
        next_l.amp_off = ~next_l.busy;
        next_l.cs_pins = route(next_l.cs_n, FLASH_SELECT_PIN_SWAP, 1'b1);
        next_l.amp_pins = route(next_l.amp_off, AMP_OFF_PIN_SWAP, 1'b1);
        next_l.tone_pins = route(next_l.pwm, TONE_OUTPUT_PIN_SWAP, 1'b0);
    end

    always_ff @(posedge timer_source_clock or negedge link_rst_n)
    begin
        if (!link_rst_n)
            l <= '{cs_n: 1'b1, amp_off: 1'b1, cs_pins: 2'h3, amp_pins: 2'h3, st: LINK_IDLE,
                   default: '0};
        else
            l <= next_l;
    end

    assign flash_sclk = l.sclk;
    assign flash_mosi = l.mosi;
    assign flash_select_n_main = l.cs_pins[0];
    assign flash_select_n_alt = l.cs_pins[1];
    assign amp_off_main = l.amp_pins[0];
    assign amp_off_alt = l.amp_pins[1];
    assign tone_out_main = l.tone_pins[0];
    assign tone_out_alt = l.tone_pins[1];
    assign debug_spi_toggle = l.dbg_spi;
    assign debug_service_toggle = l.dbg_svc;
    assign debug_timer_clock = l.dbg_clk;
    assign playing = s.busy_sync[1];
    assign clip_select = s.clip;
    sequence gap_to_cmd_s;
        l.st == LINK_GAP ##1 l.st == LINK_CMD;
    endsequence
    sequence event_then_exit_s;
        sample_event ##1 l.svc_exit;
    endsequence
    duty_load_a: assert property (@(posedge timer_source_clock) disable iff (!link_rst_n)
        sample_event && l.buf_valid && !trig |=> l.duty == $past(l.buf_data))
        else $error("duty not loaded from fetched sample");
    period_wrap_a: assert property (@(posedge timer_source_clock) disable iff (!link_rst_n)
        sample_event |=> l.tcount == 8'h00)
        else $error("timer did not wrap after 256 counts");
    fetch_ahead_a: assert property (@(posedge timer_source_clock) disable iff (!link_rst_n)
        l.busy |-> l.fetched == l.played + 32'(l.buf_valid))
        else $error("more than one sample fetched ahead");
    stop_release_a: assert property (@(posedge timer_source_clock) disable iff (!link_rst_n)
        sample_event && done_now && !trig |=> !l.busy && l.cs_n && l.st == LINK_IDLE)
        else $error("playback did not stop at clip end");
    amp_idle_a: assert property (@(posedge timer_source_clock) disable iff (!link_rst_n)
        l.amp_off == !l.busy)
        else $error("amplifier not held off while idle");
    trigger_clear_a: assert property (@(posedge timer_source_clock) disable iff (!link_rst_n)
        trig |=> l.played == 32'h0 && l.fetched == 32'h0 && !l.buf_valid && l.tcount == 8'h00)
        else $error("trigger did not clear playback state");
    sclk_rate_a: assert property (@(posedge timer_source_clock) disable iff (!link_rst_n)
        $past(l.en_sync[1]) && l.st == LINK_CMD && $past(l.st) == LINK_CMD |-> l.sclk == !l.ph)
        else $error("spi clock not at timer tick rate");
    spi_debug_a: assert property (@(posedge timer_source_clock) disable iff (!link_rst_n)
        gap_to_cmd_s |-> l.dbg_spi != $past(l.dbg_spi) || !DEBUG_ENABLE)
        else $error("spi debug pin did not toggle");
    svc_debug_a: assert property (@(posedge timer_source_clock) disable iff (!link_rst_n)
        event_then_exit_s |-> (l.dbg_svc != $past(l.dbg_svc) || !DEBUG_ENABLE)
        ##1 (l.dbg_svc == $past(l.dbg_svc, 2) || !$past(l.en_sync[1])))
        else $error("service debug pin not toggled on entry and exit");
    pin_route_a: assert property (@(posedge timer_source_clock) disable iff (!link_rst_n)
        l.tone_pins == route(l.pwm, TONE_OUTPUT_PIN_SWAP, 1'b0) && l.cs_pins[!FLASH_SELECT_PIN_SWAP])
        else $error("pin routing wrong");
    pair_button_a: assert property (@(posedge sys_clk) disable iff (!sys_rst_n)
        press_pair && !press_cyc && clk_en |=> s.clip <= 2'h1)
        else $error("pair button left the first two clips");

endmodule

// ### sim/spi_flash_model.sv
// Purpose: Serial flash that answers one continuous read for each select.
// Assumes: SPI mode 0, one command byte and a 24-bit address, MSB first.
// Notes: The byte at an address is its low byte with bit 0 forced high.
module spi_flash_model
(
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso,
    output logic [31:0] frame,
    output int bits
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] cur;
    initial
    begin
        miso = 1'b0;
        bits = 0;
        frame = 32'h0;
    end
    always @(negedge cs_n) bits = 0;
    // A released line must not hold its last level, or stale data could pass.
    always @(posedge cs_n) miso = ~miso;
    always @(posedge sclk)
    begin
        if (!cs_n && bits < 32)
            frame = {frame[30:0], mosi};
        if (!cs_n)
            bits = bits + 1;
    end
    always @(negedge sclk)
    begin
        cur = (frame[7:0] + 8'((bits - 32) / 8)) | 8'h01;
        if (!cs_n && bits >= 32)
            miso = cur[7 - ((bits - 32) % 8)];
        else
            miso = ~miso;
    end
endmodule

// ### sim/tb_flash_sample_pwm_playback.sv
// Purpose: Self-checking bench for the flash sample PWM playback block.
// Assumes: Debug on, flash select and tone routed to their alternate pins.
// Notes: Tone pulses are measured in link cycles; each should be twice the sample.
module tb_flash_sample_pwm_playback
import playback_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic link_clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic btn_cycle = 1'b0;
    logic btn_pair = 1'b0;
    logic [31:0] cnt [3] = '{32'h0, 32'h0, 32'h0};
    logic [31:0] base [3] = '{32'h0, 32'h0, 32'h0};
    logic sclk, mosi, miso, sel_main, sel_alt, amp_main, amp_alt;
    logic tone_main, tone_alt, dbg_spi, dbg_svc, dbg_tclk, playing;
    logic p_spi = 1'b0, p_svc = 1'b0, p_tclk = 1'b0, bad_route = 1'b0;
    logic [1:0] clip_select, exp_clip = 2'h0;
    logic [31:0] frame;
    int bits, run = 0, spi_tg = 0, svc_tg = 0, tclk_tg = 0, lcnt = 0, cyc = 0;
    int num_errors = 0, compares = 0;
    int pulses[$];
    int kinds[8] = '{0, 0, 1, 1, 2, 0, 1, 0};
    always #20 sys_clk = ~sys_clk;
    always #3 link_clk = ~link_clk;
    flash_sample_pwm_playback #(.DEBUG_ENABLE(1'b1), .FLASH_SELECT_PIN_SWAP(1'b1),
        .TONE_OUTPUT_PIN_SWAP(1'b1)) i_flash_sample_pwm_playback (.sys_clk(sys_clk),
        .reset_n(reset_n), .clk_en(clk_en), .timer_source_clock(link_clk),
        .btn_cycle(btn_cycle), .btn_pair(btn_pair), .clip_sample_count_0(cnt[0]),
        .clip_sample_count_1(cnt[1]), .clip_sample_count_2(cnt[2]),
        .clip_base_location_0(base[0]), .clip_base_location_1(base[1]),
        .clip_base_location_2(base[2]), .flash_miso(miso), .flash_sclk(sclk),
        .flash_mosi(mosi), .flash_select_n_main(sel_main), .flash_select_n_alt(sel_alt),
        .amp_off_main(amp_main), .amp_off_alt(amp_alt), .tone_out_main(tone_main),
        .tone_out_alt(tone_alt), .debug_spi_toggle(dbg_spi),
        .debug_service_toggle(dbg_svc), .debug_timer_clock(dbg_tclk),
        .playing(playing), .clip_select(clip_select));
    spi_flash_model i_spi_flash_model (.sclk(sclk), .cs_n(sel_alt), .mosi(mosi),
        .miso(miso), .frame(frame), .bits(bits));
    always @(posedge link_clk)
    begin
        lcnt++;
        if (tone_alt === 1'b1)
            run++;
        else if (run > 0)
        begin
            pulses.push_back(run);
            run = 0;
        end
        spi_tg += int'(dbg_spi !== p_spi);
        svc_tg += int'(dbg_svc !== p_svc);
        tclk_tg += int'(dbg_tclk !== p_tclk);
        p_spi = dbg_spi;
        p_svc = dbg_svc;
        p_tclk = dbg_tclk;
        if (reset_n && (sel_main !== 1'b1 || amp_alt !== 1'b1 || tone_main !== 1'b0))
            bad_route = 1'b1;
    end
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            num_errors++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check_bit(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    function automatic logic [1:0] nxt(input logic [1:0] c, input int k);
        if (k == 1)
            return (c == 2'h0) ? 2'h1 : 2'h0;
        return (c == 2'h2) ? 2'h0 : c + 2'h1;
    endfunction
    function automatic logic [31:0] sample_at(input logic [31:0] b, input int k);
        return {24'h0, (b[7:0] + 8'(k)) | 8'h01};
    endfunction
    // Kind 0 steps, kind 1 alternates, kind 2 presses both buttons at once.
    task automatic press(input int kind);
        spi_tg = 0;
        svc_tg = 0;
        @(posedge sys_clk);
        btn_cycle <= (kind != 1);
        btn_pair <= (kind != 0);
        repeat (3) @(posedge sys_clk);
        btn_cycle <= 1'b0;
        btn_pair <= 1'b0;
        repeat (2) @(posedge sys_clk);
        pulses.delete();
        if (clk_en)
            exp_clip = nxt(exp_clip, kind);
    endtask
    task automatic play_check(input int kind, input bit dbg);
        int i;
        int len;
        int l0;
        int t0;
        logic [31:0] b;
        press(kind);
        check_val(32'(clip_select), 32'(exp_clip), "clip select");
        len = int'(cnt[exp_clip]);
        b = base[exp_clip];
        for (i = 0; i < 20 && playing !== 1'b1; i++)
            @(posedge sys_clk);
        check_bit(playing, len != 0, "playback start");
        if (len == 0)
            return;
        check_bit(amp_main, 1'b0, "amp released");
        l0 = lcnt;
        t0 = tclk_tg;
        repeat (10) @(posedge sys_clk);
        check_val(32'(tclk_tg - t0), 32'(lcnt - l0), "timer clock out");
        for (i = 10; i < len * 90 + 100 && playing !== 1'b0; i++)
            @(posedge sys_clk);
        check_bit(i >= len * 76 - 6 && i <= len * 77 + 6, 1'b1, "duration");
        repeat (3) @(posedge sys_clk);
        check_bit(amp_main, 1'b1, "amp shutdown");
        check_bit(sel_alt, 1'b1, "select released");
        check_val(frame, {READ_CMD, b[23:0]}, "read command");
        check_val(32'(bits), 32'(32 + 8 * len), "clock count");
        check_val(32'(pulses.size()), 32'(len - 1), "pulse count");
        for (i = 0; i < len - 1 && i < pulses.size(); i++)
            check_val(32'(pulses[i]), 2 * sample_at(b, i), "duty");
        if (dbg)
        begin
            check_val(32'(spi_tg), 32'(len + 1), "spi toggles");
            check_val(32'(svc_tg), 32'(2 * len), "service toggles");
        end
        check_bit(bad_route, 1'b0, "unused pins");
    endtask
    // Lengths and bases are settled before any press reaches the block.
    task automatic load_clips();
        for (int k = 0; k < 3; k++)
        begin
            cnt[k] <= 32'(1 + $urandom_range(4));
            base[k] <= $urandom;
        end
        @(posedge sys_clk);
    endtask
    initial
    begin
        logic [1:0] nx;
        void'($urandom(32'hB551));
        repeat (12) @(posedge sys_clk);
        check_bit(sel_alt & amp_main & ~tone_alt & ~playing, 1'b1, "reset pins");
        reset_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        load_clips();
        clk_en <= 1'b0;
        press(0);
        clk_en <= 1'b1;
        repeat (3) @(posedge sys_clk);
        check_val(32'(clip_select), 32'h0, "frozen press");
        for (int i = 0; i < 8; i++)
        begin
            load_clips();
            nx = nxt(exp_clip, kinds[i]);
            if (i == 2)
                cnt[nx] <= 32'h0;
            if (i == 4)
                cnt[nx] <= 32'h1;
            if (i == 5)
                base[nx] <= 32'hFFFF_FFFE;
            play_check(kinds[i], 1'b1);
        end
        load_clips();
        cnt[nxt(exp_clip, 0)] <= 32'h5;
        press(0);
        repeat (150) @(posedge sys_clk);
        play_check(1, 1'b0);
        give_verdict();
    end
endmodule
